/* File: rtl/alarm_pkg.sv */
// Summary of operation
// - Two alarm channels, each with its own mode; mode none never raises an alarm.
// - Low mode raises the alarm when a new sample is below the alarm level.
// - High mode raises the alarm when a new sample is above the alarm level.
// - An active low alarm releases only once a sample exceeds level plus hysteresis.
// - An active high alarm releases only once a sample drops below level minus hysteresis.
// - A latching channel holds its alarm until the unlatch command arrives.
// - A non-latching channel clears when a later sample meets its release threshold.
// - One unlatch command clears every latched channel together.
// - While any alarm is active, an indicator shows the triggered channel number.
// - The unit selector offers six unit codes besides the default.
// - A non-default unit scales the displayed value by the operator's factor.
// - Selecting off returns the display to default units with raw samples.
// - Per alarm, channel number, level, mode and triggering sample are readable.
package alarm_pkg;
    // ==========================================================================
    // sizes and timing
    localparam int NUM_CH        = 2;
    localparam int MEAS_W        = 16;
    localparam int ADDR_W        = 6;
    localparam int CLK_HZ        = 100_000_000;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

    // ==========================================================================
    // types
    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_LOW  = 2'b01,
        MODE_HIGH = 2'b10
    } alarm_mode_t;

    typedef enum logic [2:0] {
        UNIT_OFF     = 3'b000,
        UNIT_VOL_PCT = 3'b001,
        UNIT_PPM     = 3'b010,
        UNIT_VPM     = 3'b011,
        UNIT_MG_M3   = 3'b100,
        UNIT_MOL_MOL = 3'b101,
        UNIT_PCT_LEL = 3'b110
    } unit_t;

    // ==========================================================================
    // register map (byte offsets)
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FACTOR   = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_CH0_CFG  = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CH0_LVL  = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_CH0_HYS  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_CH1_CFG  = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_CH1_LVL  = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_CH1_HYS  = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_CH0_TRIG = 6'h2C;
    localparam logic [ADDR_W-1:0] OFS_CH1_TRIG = 6'h30;
    localparam logic [ADDR_W-1:0] OFS_DISPLAY  = 6'h34;
    localparam logic [ADDR_W-1:0] CH_STRIDE    = 6'h0C;

    // ==========================================================================
    // fields and reset values
    localparam int CTRL_UNLATCH_BIT = 0;
    localparam int CTRL_UNIT_LSB    = 1;
    localparam int CFG_LATCH_BIT    = 2;
    localparam int STAT_NUM_LSB     = 4;
    localparam int FACTOR_FRAC      = 8;
    localparam logic [15:0] FACTOR_RST = 16'h0100;
endpackage : alarm_pkg

/* File: rtl/alarm_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module alarm_channel
    import alarm_pkg::*;
#(
    parameter int W = alarm_pkg::MEAS_W
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  sample_valid,
    input  wire logic [W-1:0]          sample,
    input  wire alarm_pkg::alarm_mode_t mode,
    input  wire logic                  latch,
    input  wire logic [W-1:0]          level,
    input  wire logic [W-1:0]          hyst,
    input  wire logic                  unlatch,
    output var  logic                  active_q,
    output var  logic [W-1:0]          trig_q
);
    import alarm_pkg::*;

    // ==========================================================================
    // thresholds widened, level+hyst by one bit and level-hyst by two signed bits, so neither wraps
    logic [W:0]   rel_low;
    logic signed [W+1:0] rel_high;
    logic         trip;
    logic         release_ok;
    logic         held;

    assign rel_low  = {1'b0, level} + {1'b0, hyst};
    assign rel_high = $signed({2'b00, level}) - $signed({2'b00, hyst});

    always_comb begin
        trip       = 1'b0;
        release_ok = 1'b0;
        unique case (mode)
            MODE_LOW: begin
                trip       = sample < level;
                release_ok = {1'b0, sample} > rel_low;
            end
            MODE_HIGH: begin
                trip       = sample > level;
                release_ok = $signed({2'b00, sample}) < rel_high;
            end
            default: begin
                trip       = 1'b0;
                release_ok = 1'b0;
            end
        endcase
    end

    // unlatch takes effect first so a trip in the same cycle still wins
    assign held = active_q & ~(unlatch & latch);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
        end else if (mode != MODE_LOW && mode != MODE_HIGH) begin
            active_q <= 1'b0;
        end else if (sample_valid) begin
            if (!held) begin
                active_q <= trip;
            end else if (!latch) begin
                active_q <= ~release_ok;
            end else begin
                active_q <= 1'b1;
            end
        end else begin
            active_q <= held;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= '0;
        end else if (sample_valid && !held && trip) begin
            trig_q <= sample;
        end
    end

    // ==========================================================================
    // assertions
    a_none_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
        (mode == MODE_NONE) |=> !active_q)
        else $error("alarm active while mode is none");
    a_low_trip: assert property (@(posedge mclk) disable iff (!arst_n)
        (sample_valid && mode == MODE_LOW && sample < level) |=> active_q)
        else $error("low alarm did not trip");
    a_high_trip: assert property (@(posedge mclk) disable iff (!arst_n)
        (sample_valid && mode == MODE_HIGH && sample > level) |=> active_q)
        else $error("high alarm did not trip");
    a_low_hold_band: assert property (@(posedge mclk) disable iff (!arst_n)
        (active_q && !unlatch && mode == MODE_LOW && sample_valid &&
         {1'b0, sample} <= {1'b0, level} + {1'b0, hyst}) |=> active_q)
        else $error("low alarm released inside hysteresis band");
    a_high_release: assert property (@(posedge mclk) disable iff (!arst_n)
        (active_q && !latch && mode == MODE_HIGH && sample_valid &&
         {1'b0, sample} + {1'b0, hyst} < {1'b0, level}) |=> !active_q)
        else $error("high alarm did not release below level minus hysteresis");
    a_latch_holds: assert property (@(posedge mclk) disable iff (!arst_n)
        (active_q && latch && !unlatch && mode != MODE_NONE) ##1
        (mode != MODE_NONE) |-> active_q)
        else $error("latched alarm dropped without unlatch");
    a_unlatch_clears: assert property (@(posedge mclk) disable iff (!arst_n)
        (active_q && latch && unlatch && !sample_valid) |=> !active_q)
        else $error("unlatch did not clear latched alarm");
    c_low_trip: cover property (@(posedge mclk) disable iff (!arst_n)
        mode == MODE_LOW && !active_q ##1 active_q);
    c_high_release: cover property (@(posedge mclk) disable iff (!arst_n)
        mode == MODE_HIGH && active_q && !latch ##1 !active_q);
    c_unlatch: cover property (@(posedge mclk) disable iff (!arst_n)
        active_q && latch && unlatch ##1 !active_q);
endmodule : alarm_channel
`default_nettype wire

/* File: rtl/alarm_hyst_top.sv */
`timescale 1ns/100ps
`default_nettype none
module alarm_hyst_top
    import alarm_pkg::*;
#(
    parameter int W          = alarm_pkg::MEAS_W,
    parameter int BLINK_HALF = alarm_pkg::BLINK_HALF_CYC
) (
    input  wire logic                         mclk,
    input  wire logic                         arst_n,
    input  wire logic [alarm_pkg::ADDR_W-1:0] address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [31:0]                  writedata,
    input  wire logic [3:0]                   byteenable,
    output var  logic [31:0]                  readdata,
    output var  logic                         waitrequest,
    input  wire logic                         sample_valid,
    input  wire logic [W-1:0]                 sample_data,
    output var  logic                         alarm_lamp,
    output var  logic [1:0]                   alarm_num,
    output var  logic [alarm_pkg::NUM_CH-1:0] alarm_active,
    output var  logic [W-1:0]                 display_value,
    output var  logic [2:0]                   display_unit,
    output var  logic                         irq
);
    import alarm_pkg::*;

    // ==========================================================================
    // parameter checks
    if (W < 2 || W > 16) begin : g_bad_w
        $error("measurement width must be 2..16");
    end
    if (BLINK_HALF < 2) begin : g_bad_blink
        $error("blink half period must be at least 2 cycles");
    end

    // ==========================================================================
    // declarations
    logic                     wait_q;
    logic [31:0]              rdata_q;
    logic                     wr_fire;
    logic                     unlatch_q;
    unit_t                    unit_q;
    logic [15:0]              factor_q;
    alarm_mode_t              mode_q  [NUM_CH];
    logic                     latch_q [NUM_CH];
    logic [W-1:0]             level_q [NUM_CH];
    logic [W-1:0]             hyst_q  [NUM_CH];
    logic [W-1:0]             trig    [NUM_CH];
    logic [NUM_CH-1:0]        act;
    logic [NUM_CH-1:0]        act_prev_q;
    logic [NUM_CH-1:0]        int_stat_q;
    logic [NUM_CH-1:0]        int_mask_q;
    logic [NUM_CH-1:0]        int_stat_d;
    logic [NUM_CH-1:0]        w1c;
    logic [31:0]              rdata_d;
    logic [31:0]              blink_cnt_q;
    logic                     lamp_q;
    logic [1:0]               num_q;
    logic [W-1:0]             disp_q;

    function automatic logic [W-1:0] scale(input logic [W-1:0] s, input logic [15:0] f);
        logic [W+15:0] prod;
        logic [W+15:0] shifted;
        prod    = {{16{1'b0}}, s} * {{W{1'b0}}, f};
        shifted = prod >> FACTOR_FRAC;
        if (|shifted[W+15:W]) begin
            scale = '1;
        end else begin
            scale = shifted[W-1:0];
        end
    endfunction : scale

    function automatic logic [ADDR_W-1:0] word(input logic [ADDR_W-1:0] a);
        word = {a[ADDR_W-1:2], 2'b00};
    endfunction : word

    // ==========================================================================
    // avalon slave: one wait cycle, write lands on the waitrequest-low edge
    assign wr_fire = write && !wait_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((read || write) && wait_q);
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (word(address))
            OFS_CTRL:     rdata_d[CTRL_UNIT_LSB +: 3] = unit_q;
            OFS_FACTOR:   rdata_d[15:0] = factor_q;
            OFS_CH0_CFG:  rdata_d[CFG_LATCH_BIT:0] = {latch_q[0], mode_q[0]};
            OFS_CH0_LVL:  rdata_d[W-1:0] = level_q[0];
            OFS_CH0_HYS:  rdata_d[W-1:0] = hyst_q[0];
            OFS_CH1_CFG:  rdata_d[CFG_LATCH_BIT:0] = {latch_q[1], mode_q[1]};
            OFS_CH1_LVL:  rdata_d[W-1:0] = level_q[1];
            OFS_CH1_HYS:  rdata_d[W-1:0] = hyst_q[1];
            OFS_STATUS:   rdata_d[STAT_NUM_LSB+1:0] = {num_q, 2'b00, act};
            OFS_INT_STAT: rdata_d[NUM_CH-1:0] = int_stat_q;
            OFS_INT_MASK: rdata_d[NUM_CH-1:0] = int_mask_q;
            OFS_CH0_TRIG: rdata_d[W-1:0] = trig[0];
            OFS_CH1_TRIG: rdata_d[W-1:0] = trig[1];
            OFS_DISPLAY:  rdata_d[W-1:0] = disp_q;
            default:      rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (read && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================================
    // configuration registers; byte lane 0 carries control, lanes 0-1 levels
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unlatch_q <= 1'b0;
            unit_q    <= UNIT_OFF;
            factor_q  <= FACTOR_RST;
        end else begin
            unlatch_q <= wr_fire && word(address) == OFS_CTRL && byteenable[0] &&
                         writedata[CTRL_UNLATCH_BIT];
            if (wr_fire && word(address) == OFS_CTRL && byteenable[0] &&
                writedata[CTRL_UNIT_LSB +: 3] <= UNIT_PCT_LEL) begin
                unit_q <= unit_t'(writedata[CTRL_UNIT_LSB +: 3]);
            end
            if (wr_fire && word(address) == OFS_FACTOR) begin
                if (byteenable[0]) factor_q[7:0]  <= writedata[7:0];
                if (byteenable[1]) factor_q[15:8] <= writedata[15:8];
            end
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_cfg
        localparam logic [ADDR_W-1:0] CFG = OFS_CH0_CFG + ADDR_W'(c) * CH_STRIDE;
        localparam logic [ADDR_W-1:0] LVL = OFS_CH0_LVL + ADDR_W'(c) * CH_STRIDE;
        localparam logic [ADDR_W-1:0] HYS = OFS_CH0_HYS + ADDR_W'(c) * CH_STRIDE;
        logic [31:0] lvl_wr;
        logic [31:0] hys_wr;
        assign lvl_wr = {{(32-W){1'b0}}, level_q[c]};
        assign hys_wr = {{(32-W){1'b0}}, hyst_q[c]};

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                mode_q[c]  <= MODE_NONE;
                latch_q[c] <= 1'b0;
                level_q[c] <= '0;
                hyst_q[c]  <= '0;
            end else if (wr_fire) begin
                if (word(address) == CFG && byteenable[0]) begin
                    mode_q[c]  <= (writedata[1:0] == MODE_LOW ||
                                   writedata[1:0] == MODE_HIGH) ?
                                  alarm_mode_t'(writedata[1:0]) : MODE_NONE;
                    latch_q[c] <= writedata[CFG_LATCH_BIT];
                end
                if (word(address) == LVL) begin
                    level_q[c] <= W'({byteenable[1] ? writedata[15:8] : lvl_wr[15:8],
                                      byteenable[0] ? writedata[7:0]  : lvl_wr[7:0]});
                end
                if (word(address) == HYS) begin
                    hyst_q[c] <= W'({byteenable[1] ? writedata[15:8] : hys_wr[15:8],
                                     byteenable[0] ? writedata[7:0]  : hys_wr[7:0]});
                end
            end
        end

        alarm_channel #(.W(W)) u_ch (
            .mclk         (mclk),
            .arst_n       (arst_n),
            .sample_valid (sample_valid),
            .sample       (sample_data),
            .mode         (mode_q[c]),
            .latch        (latch_q[c]),
            .level        (level_q[c]),
            .hyst         (hyst_q[c]),
            .unlatch      (unlatch_q),
            .active_q     (act[c]),
            .trig_q       (trig[c])
        );
    end

    // ==========================================================================
    // interrupts: rising alarm sets a sticky bit; the set beats a w1c clear
    assign w1c = (wr_fire && word(address) == OFS_INT_STAT && byteenable[0]) ?
                 writedata[NUM_CH-1:0] : '0;
    assign int_stat_d = (int_stat_q & ~w1c) | (act & ~act_prev_q);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            act_prev_q <= '0;
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq        <= 1'b0;
        end else begin
            act_prev_q <= act;
            int_stat_q <= int_stat_d;
            if (wr_fire && word(address) == OFS_INT_MASK && byteenable[0]) begin
                int_mask_q <= writedata[NUM_CH-1:0];
            end
            irq <= |(int_stat_d & ((wr_fire && word(address) == OFS_INT_MASK &&
                    byteenable[0]) ? writedata[NUM_CH-1:0] : int_mask_q));
        end
    end

    // ==========================================================================
    // indicators: channel number and blinking lamp
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            num_q <= 2'h0;
        end else begin
            num_q <= act[0] ? 2'h1 : (act[1] ? 2'h2 : 2'h0);
        end
    end

    // the lamp restarts its on phase with each new alarm episode
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            blink_cnt_q <= 32'h0000_0000;
            lamp_q      <= 1'b0;
        end else if (act == '0) begin
            blink_cnt_q <= 32'h0000_0000;
            lamp_q      <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_HALF - 1) || !lamp_q && blink_cnt_q == '0 &&
                     act_prev_q == '0) begin
            blink_cnt_q <= 32'h0000_0000;
            lamp_q      <= ~lamp_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================================
    // display value: raw in default units, scaled otherwise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            disp_q <= '0;
        end else if (sample_valid) begin
            disp_q <= (unit_q == UNIT_OFF) ? sample_data :
                      scale(sample_data, factor_q);
        end
    end

    assign readdata      = rdata_q;
    assign waitrequest   = wait_q;
    assign alarm_lamp    = lamp_q;
    assign alarm_num     = num_q;
    assign alarm_active  = act;
    assign display_value = disp_q;
    assign display_unit  = unit_q;

    // ==========================================================================
    // assertions
    a_bus_one_wait: assert property (@(posedge mclk) disable iff (!arst_n)
        ((read || write) && wait_q) |=> !wait_q ##1 wait_q)
        else $error("bus answer not exactly one cycle after request");
    a_num_tracks: assert property (@(posedge mclk) disable iff (!arst_n)
        act[0] |=> num_q == 2'h1)
        else $error("indicator does not show channel 1");
    a_lamp_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        (act == '0) |=> !lamp_q)
        else $error("lamp lit with no alarm");
    a_lamp_starts: assert property (@(posedge mclk) disable iff (!arst_n)
        (act_prev_q == '0 && act != '0) |=> lamp_q)
        else $error("lamp did not light on new alarm");
    a_unit_raw: assert property (@(posedge mclk) disable iff (!arst_n)
        (sample_valid && unit_q == UNIT_OFF) |=> disp_q == $past(sample_data))
        else $error("default units not raw sample");
    a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
        irq == |(int_stat_q & int_mask_q))
        else $error("irq disagrees with masked status");
    a_set_wins: assert property (@(posedge mclk) disable iff (!arst_n)
        (act[0] && !act_prev_q[0]) |=> int_stat_q[0])
        else $error("alarm event lost");
    // a sticky bit may only fall through a one written to it
    a_stat_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
        (int_stat_q[0] && !w1c[0]) |=> int_stat_q[0])
        else $error("status bit dropped without a clear");
    a_num_second: assert property (@(posedge mclk) disable iff (!arst_n)
        (act == 2'b10) |=> num_q == 2'h2)
        else $error("indicator does not show channel 2");
    // a refused unit code must leave the current selection alone
    a_unit_refused: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_fire && word(address) == OFS_CTRL && byteenable[0] &&
         writedata[CTRL_UNIT_LSB +: 3] > UNIT_PCT_LEL) |=> unit_q == $past(unit_q))
        else $error("refused unit code was stored");
    // unity factor is the one scaling whose result is known without arithmetic
    a_unity_scale: assert property (@(posedge mclk) disable iff (!arst_n)
        (sample_valid && unit_q != UNIT_OFF && factor_q == FACTOR_RST) |=>
        disp_q == $past(sample_data))
        else $error("unity factor altered the displayed value");
    c_both_alarms: cover property (@(posedge mclk) disable iff (!arst_n) act == 2'b11);
    c_lamp_blinks: cover property (@(posedge mclk) disable iff (!arst_n)
        lamp_q ##1 !lamp_q && act != '0);
endmodule : alarm_hyst_top
`default_nettype wire

/* File: test/meas_source.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// sample source: one-cycle strobe, data line scrambled outside the strobe
module meas_source (
    input  wire logic        mclk,
    output var  logic        sample_valid,
    output var  logic [15:0] sample_data
);
    initial begin
        sample_valid = 1'b0;
        sample_data  = 16'h0000;
    end
    task automatic send(input logic [15:0] v);
        @(posedge mclk);
        sample_valid <= 1'b1;
        sample_data  <= v;
        @(posedge mclk);
        sample_valid <= 1'b0;
        sample_data  <= ~v; // stale data must never look valid
    endtask : send
endmodule : meas_source
`default_nettype wire

/* File: test/alarm_hyst_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module alarm_hyst_top_test;
    import alarm_pkg::*;
    logic        mclk, arst_n, read, write, waitrequest, sample_valid, alarm_lamp, irq;
    logic [5:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [1:0]  alarm_num, alarm_active;
    logic [15:0] sample_data, display_value;
    logic [2:0]  display_unit;
    int          err_total, checks, ones;
    alarm_hyst_top #(.BLINK_HALF(4)) i_alarm_hyst_top (.mclk, .arst_n, .address, .read,
        .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .sample_valid,
        .sample_data, .alarm_lamp, .alarm_num, .alarm_active, .display_value,
        .display_unit, .irq);
    meas_source i_meas_source (.mclk, .sample_valid, .sample_data);
    // ==========================================================================
    // shared tasks
    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        address   <= a;
        writedata <= d;
        write     <= w;
        read      <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (n == 20) begin
            err_total++;
            close_out();
        end
        repeat (2) @(posedge mclk); // let registered effects land
    endtask : bus
    task automatic cfg(input int c, input logic [31:0] m, input logic [31:0] l, h);
        bus(1'b1, OFS_CH0_LVL + 6'(c * 12), l);
        bus(1'b1, OFS_CH0_HYS + 6'(c * 12), h);
        bus(1'b1, OFS_CH0_CFG + 6'(c * 12), m);
    endtask : cfg
    task automatic smp(input logic [15:0] v);
        i_meas_source.send(v);
        repeat (3) @(posedge mclk);
    endtask : smp
    // ==========================================================================
    // scenarios
    task automatic t_none();
        cfg(0, 32'h0, 32'h0064, 32'h000A);
        smp(16'h0000);
        chk("none lo", 32'h0, alarm_active);
        smp(16'hFFFF);
        chk("none hi", 32'h0, alarm_active);
        cfg(0, 32'h3, 32'h0064, 32'h000A);
        smp(16'h0000);
        chk("mode3", 32'h0, alarm_active);
        bus(1'b0, OFS_CH0_CFG, 32'h0);
        chk("mode3 cfg", 32'h0, rd);
    endtask : t_none
    task automatic t_low();
        cfg(0, 32'h1, 32'h0064, 32'h000A);
        smp(16'h0064);
        chk("low eq", 32'h0, alarm_active);
        smp(16'h0063);
        chk("low trip", 32'h1, alarm_active);
        chk("num", 32'h1, alarm_num);
        bus(1'b0, OFS_CH0_TRIG, 32'h0);
        chk("trig", 32'h0063, rd);
        smp(16'h006E);
        chk("low hold", 32'h1, alarm_active);
        smp(16'h006F);
        chk("low rel", 32'h0, alarm_active);
    endtask : t_low
    task automatic t_latch();
        cfg(1, 32'h2, 32'h00C8, 32'h0014);
        smp(16'h00C9);
        chk("high trip", 32'h2, alarm_active);
        chk("num2", 32'h2, alarm_num);
        smp(16'h00B5);
        chk("high hold", 32'h2, alarm_active);
        smp(16'h00B3);
        chk("high rel", 32'h0, alarm_active);
        cfg(1, 32'h6, 32'h00C8, 32'h0014);
        cfg(0, 32'h5, 32'h0064, 32'h000A);
        smp(16'h00C9);
        smp(16'h0032);
        chk("latched", 32'h3, alarm_active);
        chk("num both", 32'h1, alarm_num);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h13, rd);
        bus(1'b0, OFS_CH1_TRIG, 32'h0);
        chk("trig2", 32'h00C9, rd);
        bus(1'b0, OFS_CH1_CFG, 32'h0);
        chk("cfg2", 32'h6, rd);
        bus(1'b1, OFS_CTRL, 32'h1);
        chk("unlatch", 32'h0, alarm_active);
    endtask : t_latch
    task automatic t_irq();
        cfg(1, 32'h0, 32'h0, 32'h0);
        cfg(0, 32'h1, 32'h0064, 32'h000A);
        bus(1'b1, OFS_INT_STAT, 32'h3);
        bus(1'b1, OFS_INT_MASK, 32'h1);
        smp(16'h0063);
        chk("irq", 32'h1, irq);
        ones = 0;
        repeat (16) @(posedge mclk) ones += int'(alarm_lamp === 1'b1);
        chk("blink", 32'h1, 32'(ones > 4 && ones < 12));
        bus(1'b1, OFS_INT_MASK, 32'h0);
        chk("irq masked", 32'h0, irq);
        bus(1'b1, OFS_INT_STAT, 32'h1);
        bus(1'b0, OFS_INT_STAT, 32'h0);
        chk("int clr", 32'h0, rd);
    endtask : t_irq
    task automatic t_unit();
        for (int u = 1; u < 7; u++) begin
            bus(1'b1, OFS_CTRL, 32'(u << 1));
            chk("unit", 32'(u), display_unit);
        end
        bus(1'b1, OFS_CTRL, 32'hE);
        chk("unit7", 32'h6, display_unit);
        bus(1'b1, OFS_FACTOR, 32'h0200);
        smp(16'h0010);
        chk("scaled", 32'h0020, display_value);
        bus(1'b1, OFS_CTRL, 32'h0);
        smp(16'h0010);
        chk("raw", 32'h0010, display_value);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask : t_unit
    // ==========================================================================
    // clock and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {arst_n, read, write, address, writedata} = '0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        bus(1'b0, OFS_FACTOR, 32'h0);
        chk("factor rst", 32'h0100, rd);
        t_none();
        t_low();
        t_latch();
        t_irq();
        t_unit();
        close_out();
    end
endmodule : alarm_hyst_top_test
`default_nettype wire
